// file: inc/codec_clk_pkg.sv
// Constants, types and decode helpers for mode and clock setup.
// Assumes a 200 MHz system clock.
package codec_clk_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ    = 200;                       // System clock rate
   localparam int WINDOW_MS  = 10;                        // Port-enable window
   localparam int WINDOW_CYC = WINDOW_MS * 1000 * CLK_MHZ;
   localparam int PWRUP_US   = 85;                        // Power-up time
   localparam int PWRUP_CYC  = PWRUP_US * CLK_MHZ;
   localparam int STRAP_CYC  = 4;                         // Strap sample point

   // ------------------------------------------------------------------
   // Register map, fields and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_MODE1  = 8'h01;  // mode_control_one
   localparam logic [7:0] ADDR_POWER  = 8'h07;  // power_and_port_enable
   localparam logic [7:0] ADDR_STATUS = 8'h08;  // Read-only status
   localparam int MODE1_SPEED_LSB = 6;          // Speed select, two bits
   localparam int MODE1_RATIO_HI  = 5;          // clock_ratio_upper
   localparam int MODE1_RATIO_LO  = 4;          // clock_ratio_lower
   localparam int MODE1_MASTER    = 3;          // Master/slave select
   localparam int MODE1_SLOW_FILT = 2;          // Slow roll-off filter
   localparam int MODE1_FMT_I2S   = 0;          // I2S when set
   localparam int POWER_PDN       = 0;          // power_down_bit
   localparam int POWER_PORT_ENABLE_BIT      = 1;          // port_enable_bit
   localparam logic [7:0] MODE1_RST = 8'h00;    // Slave, single, LJ
   localparam logic [7:0] POWER_RST = 8'h00;
   localparam logic [6:0] CHIP_ADDR = 7'h2a;    // Arbitrary value

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SPD_SINGLE = 2'h0,
      SPD_DOUBLE = 2'h1,
      SPD_QUAD   = 2'h2
   } speed_t;

   // Gray codes along wait -> down -> up -> run
   typedef enum logic [2:0] {
      ST_WAIT    = 3'h0,
      ST_CP_DOWN = 3'h1,
      ST_CP_UP   = 3'h3,
      ST_CP_RUN  = 3'h2,
      ST_PIN_RUN = 3'h4
   } mode_st_t;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Speed select decode: 00 and 01 single, 10 double, 11 quad
   function automatic speed_t spd_decode(input logic [1:0] sel);
      spd_decode = !sel[1] ? SPD_SINGLE : (sel[0] ? SPD_QUAD : SPD_DOUBLE);
   endfunction

   // Log2 of master clocks per frame; lower ratio bit unused
   function automatic logic [3:0] ratio_log2(input speed_t spd, input logic hi);
      case (spd)
         SPD_SINGLE: ratio_log2 = hi ? 4'h9 : 4'h8;
         SPD_DOUBLE: ratio_log2 = hi ? 4'h8 : 4'h7;
         default:    ratio_log2 = 4'h7;
      endcase
   endfunction

endpackage

// file: hw/ctrl_port_slave.sv
// Serial control port slave: chip address byte, map byte, data bytes.
// Assumes async pins and a port clock far slower than clk_i.
module ctrl_port_slave (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Port pins
   input  wire logic       cclk_i,
   input  wire logic       cs_b_i,
   input  wire logic       cdin_i,
   output logic            cdout_o,
   output logic            cdout_oe_b_o,
   // Register side
   output logic            wr_o,
   output logic [7:0]      waddr_o,
   output logic [7:0]      wdata_o,
   output logic [7:0]      map_o,
   input  wire logic [7:0] rdata_i
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] s1;      // First sync stage: {cclk, cs_b, cdin}
      logic [2:0] s2;      // Second sync stage
      logic       cclk_d;  // Delayed port clock for edges
      logic [7:0] shift;   // Incoming bits
      logic [2:0] bitcnt;  // Bit within byte
      logic [1:0] bytecnt; // Byte within frame, saturates at 2
      logic       sel;     // Chip address matched
      logic       rw;      // Read frame
      logic [7:0] map;     // Register pointer
      logic [7:0] dsr;     // Outgoing bits
      logic       dout;    // Pin level
      logic       wr;      // Write strobe
      logic [7:0] waddr;
      logic [7:0] wdata;
   } cps_t;

   cps_t r;    // Registered state
   cps_t n;    // Next state
   logic [7:0] byte_in; // Byte completed on this edge

   // Next state
   always_comb begin
      n = r;
      n.s1 = {cclk_i, cs_b_i, cdin_i};
      n.s2 = r.s1;
      n.cclk_d = r.s2[2];
      n.wr = 1'b0;
      byte_in = {r.shift[6:0], r.s2[0]};
      if (r.s2[1]) begin
         // Deselected: frame ends, pointer kept
         n.bitcnt = '0;
         n.bytecnt = '0;
         n.sel = 1'b0;
         n.rw = 1'b0;
      end else if (r.s2[2] && !r.cclk_d) begin
         // Rising port clock: sample one bit
         n.shift = byte_in;
         n.bitcnt = r.bitcnt + 3'h1;
         if (r.bitcnt == 3'h7) begin
            case (r.bytecnt)
               2'h0: begin
                  n.sel = (byte_in[7:1] == codec_clk_pkg::CHIP_ADDR);
                  n.rw = byte_in[0];
                  n.dout = rdata_i[7];
                  n.dsr = rdata_i;
               end
               2'h1: begin
                  if (r.sel && !r.rw) begin
                     n.map = byte_in;
                  end
               end
               default: begin
                  // Data byte: write at pointer, then step pointer
                  if (r.sel && !r.rw) begin
                     n.wr = 1'b1;
                     n.waddr = r.map;
                     n.wdata = byte_in;
                     n.map = r.map + 8'h01;
                  end
               end
            endcase
            if (r.bytecnt != 2'h2) begin
               n.bytecnt = r.bytecnt + 2'h1;
            end
         end
      end else if (!r.s2[2] && r.cclk_d && r.sel && r.rw && r.bytecnt != 2'h0) begin
         // Each fall in a read puts out the next bit, bit 7 first
         n.dout = r.dsr[7];
         n.dsr = {r.dsr[6:0], 1'b0};
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Outputs
   assign cdout_o      = r.dout;
   assign cdout_oe_b_o = ~(r.sel & r.rw & ~r.s2[1]);
   assign wr_o         = r.wr;
   assign waddr_o      = r.waddr;
   assign wdata_o      = r.wdata;
   assign map_o        = r.map;

endmodule

// file: hw/codec_clk_ctrl.sv
// Mode selection, control-port entry, power-up and clock generation.
// Assumes async pins, and master and crystal clocks
// well below clk_i (200 MHz).
//
// Contract
// - Pin mode always uses fast roll-off filter
// - Speed pins: 0x single, 10 double, 11 quad
// - De-emphasis only when both speed pins low
// - Format pin high I2S, low left-justified
// - Reset low restores register defaults
// - After reset: low power, port accessible
// - Internal master clock out within 1 ms
// - Clearing power-down starts 85 us power-up
// - Master drives frame and 64x bit clocks
// - Port mode defaults slave, master via 01h
// - Sample rates 4 to 200 kHz, three speeds
// - Crystal fitted: buffered clock driven out
// - Upper ratio bit picks master-clock ratio in single and double speed
// - Don't-care ratio bits are ignored
// - Pin mode slave unless output pin pulled up
module codec_clk_ctrl #(
   parameter int WINDOW_CYCLES = codec_clk_pkg::WINDOW_CYC, // Port-enable window
   parameter int PWRUP_CYCLES  = codec_clk_pkg::PWRUP_CYC   // Power-up time
) (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_b_i,
   // Mode pins
   input  wire logic   speed_select_high_i,
   input  wire logic   speed_select_low_i,
   input  wire logic   format_select_pin_i,
   input  wire logic   serial_data_out_i,
   input  wire logic   crystal_fitted_i,
   // Clock pins
   input  wire logic   crystal_input_i,
   input  wire logic   mclk_i,
   output logic        mclk_o,
   output logic        mclk_oe_b_o,
   input  wire logic   frame_clock_i,
   output logic        frame_clock_o,
   output logic        frame_clock_oe_b_o,
   input  wire logic   bit_clock_i,
   output logic        bit_clock_o,
   output logic        bit_clock_oe_b_o,
   // Control port pins
   input  wire logic   cclk_i,
   input  wire logic   cs_b_i,
   input  wire logic   cdin_i,
   output logic        cdout_o,
   output logic        cdout_oe_b_o,
   // Mode outputs to the converter core
   output codec_clk_pkg::speed_t speed_mode_o,
   output logic        deemph_44k_o,
   output logic        format_i2s_o,
   output logic        fast_filter_o,
   output logic        master_mode_o,
   output logic        low_power_o
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   // Pin bundle through the two-flop synchroniser
   typedef struct packed {
      logic m1;     // speed_select_high
      logic m0;     // speed_select_low
      logic fmt;    // format_select_pin
      logic sdo;    // serial_data_out strap
      logic xfit;   // Crystal fitted strap
      logic crystal_input;    // crystal_input
      logic mclk;   // Master clock input
      logic fclk;   // Frame clock input
      logic bclk;   // Bit clock input
   } pins_t;

   typedef struct packed {
      pins_t                   s1;      // First sync stage
      pins_t                   s2;      // Second sync stage
      logic                    mck_d;   // Delayed master clock source
      codec_clk_pkg::mode_st_t st;      // Operating state
      logic [20:0]             tmr;     // Window and power-up timer
      logic                    s_mst;   // Captured master strap
      logic                    s_xtal;  // Captured crystal strap
      logic [7:0]              mode1;   // mode_control_one
      logic [7:0]              power;   // power_and_port_enable
      logic [8:0]              div;     // Master clock divider
      logic                    mclk;    // Buffered crystal clock
      logic                    fclk;    // Generated frame clock
      logic                    bclk;    // Generated bit clock
      codec_clk_pkg::speed_t   speed;
      logic                    deemph;
      logic                    i2s;
      logic                    fast;
      logic                    master;
   } ctl_t;

   ctl_t       r;       // Registered state
   ctl_t       n;       // Next state
   logic       wr;      // Write strobe from control port
   logic [7:0] waddr;   // Write address
   logic [7:0] wdata;   // Write data
   logic [7:0] map;     // Read pointer
   logic [7:0] rdata;   // Read data
   logic       run;     // Normal operation
   logic       src;     // Selected master clock level
   logic       rise;    // Master clock rising edge
   logic [3:0] lg;      // Log2 of master clocks per frame

   // ------------------------------------------------------------------
   // Control port
   // ------------------------------------------------------------------
   ctrl_port_slave u_port (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .cclk_i       (cclk_i),
      .cs_b_i       (cs_b_i),
      .cdin_i       (cdin_i),
      .cdout_o      (cdout_o),
      .cdout_oe_b_o (cdout_oe_b_o),
      .wr_o         (wr),
      .waddr_o      (waddr),
      .wdata_o      (wdata),
      .map_o        (map),
      .rdata_i      (rdata)
   );

   // Read mux; unmapped addresses read zero
   always_comb begin
      case (map)
         codec_clk_pkg::ADDR_MODE1:  rdata = r.mode1;
         codec_clk_pkg::ADDR_POWER:  rdata = r.power;
         codec_clk_pkg::ADDR_STATUS: rdata = {1'b0, r.s2.fclk, r.s2.bclk,
                                              r.s_xtal, r.master, r.st};
         default:                    rdata = 8'h00;
      endcase
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      n = r;
      n.s1 = '{speed_select_high_i, speed_select_low_i, format_select_pin_i,
               serial_data_out_i, crystal_fitted_i, crystal_input_i,
               mclk_i, frame_clock_i, bit_clock_i};
      n.s2 = r.s1;

      // Straps caught once synced after release
      if (r.st == codec_clk_pkg::ST_WAIT &&
          r.tmr == 21'(codec_clk_pkg::STRAP_CYC - 1)) begin
         n.s_mst = r.s2.sdo;
         n.s_xtal = r.s2.xfit;
      end

      // crystal copy out; else mclk pin in
      n.mclk = r.s2.crystal_input;
      src = r.s_xtal ? r.s2.crystal_input : r.s2.mclk;
      n.mck_d = src;
      rise = src & ~r.mck_d;

      // Register writes; ignored in pin mode
      // port accepted in low power
      if (wr && r.st != codec_clk_pkg::ST_PIN_RUN) begin
         if (waddr == codec_clk_pkg::ADDR_MODE1) begin
            n.mode1 = wdata;
         end else if (waddr == codec_clk_pkg::ADDR_POWER) begin
            n.power = wdata;
         end
      end

      // Operating state
      case (r.st)
         codec_clk_pkg::ST_WAIT: begin
            n.tmr = r.tmr + 21'h1;
            if (n.power[codec_clk_pkg::POWER_PORT_ENABLE_BIT]) begin
               n.tmr = '0;
               n.st = n.power[codec_clk_pkg::POWER_PDN] ?
                      codec_clk_pkg::ST_CP_DOWN : codec_clk_pkg::ST_CP_UP;
            end else if (r.tmr == 21'(WINDOW_CYCLES - 1)) begin
               // Window missed: run from the pins
               n.st = codec_clk_pkg::ST_PIN_RUN;
            end
         end
         codec_clk_pkg::ST_CP_DOWN: begin
            if (!n.power[codec_clk_pkg::POWER_PDN]) begin
               n.tmr = '0;
               n.st = codec_clk_pkg::ST_CP_UP;
            end
         end
         codec_clk_pkg::ST_CP_UP: begin
            n.tmr = r.tmr + 21'h1;
            if (n.power[codec_clk_pkg::POWER_PDN]) begin
               n.st = codec_clk_pkg::ST_CP_DOWN;
            end else if (r.tmr == 21'(PWRUP_CYCLES - 1)) begin
               n.st = codec_clk_pkg::ST_CP_RUN;
            end
         end
         codec_clk_pkg::ST_CP_RUN: begin
            if (n.power[codec_clk_pkg::POWER_PDN]) begin
               n.st = codec_clk_pkg::ST_CP_DOWN;
            end
         end
         codec_clk_pkg::ST_PIN_RUN: begin
            n.st = codec_clk_pkg::ST_PIN_RUN;
         end
         default: begin
            n.st = codec_clk_pkg::ST_WAIT;
         end
      endcase

      // Mode decode from pins or from register
      if (r.st == codec_clk_pkg::ST_PIN_RUN) begin
         n.speed = codec_clk_pkg::spd_decode({r.s2.m1, r.s2.m0});
         n.deemph = !r.s2.m1 && !r.s2.m0;
         n.i2s = r.s2.fmt;
         n.fast = 1'b1;
         n.master = r.s_mst;
         lg = codec_clk_pkg::ratio_log2(n.speed, 1'b0);
      end else begin
         n.speed = codec_clk_pkg::spd_decode(
                      r.mode1[codec_clk_pkg::MODE1_SPEED_LSB +: 2]);
         n.deemph = 1'b0;
         n.i2s = r.mode1[codec_clk_pkg::MODE1_FMT_I2S];
         n.fast = !r.mode1[codec_clk_pkg::MODE1_SLOW_FILT];
         n.master = r.mode1[codec_clk_pkg::MODE1_MASTER];
         // upper bit sets ratio in single and double speed; lower bit unused
         lg = codec_clk_pkg::ratio_log2(n.speed,
                 r.mode1[codec_clk_pkg::MODE1_RATIO_HI]);
      end

      // frame and 64x bit clock from master clock
      run = (r.st == codec_clk_pkg::ST_CP_RUN) ||
            (r.st == codec_clk_pkg::ST_PIN_RUN);
      if (!(run && r.master)) begin
         n.div = '0;
      end else if (rise) begin
         n.div = r.div + 9'h001;
      end
      // Left half is low for I2S and high for left-justified
      n.fclk = n.div[lg - 4'h1] ^ ~n.i2s;
      n.bclk = n.div[lg - 4'h7];
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // reset restores register defaults
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
         r.mode1 <= codec_clk_pkg::MODE1_RST;
         r.power <= codec_clk_pkg::POWER_RST;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // crystal copy out after strap capture
   assign mclk_o             = r.mclk;
   assign mclk_oe_b_o        = ~r.s_xtal;
   assign frame_clock_o      = r.fclk;
   assign bit_clock_o        = r.bclk;
   // Slave mode leaves both clock pins undriven
   assign frame_clock_oe_b_o = ~(r.master && (r.st == codec_clk_pkg::ST_CP_RUN ||
                                              r.st == codec_clk_pkg::ST_PIN_RUN));
   assign bit_clock_oe_b_o   = frame_clock_oe_b_o;
   assign speed_mode_o       = r.speed;
   assign deemph_44k_o       = r.deemph;
   assign format_i2s_o       = r.i2s;
   assign fast_filter_o      = r.fast;
   assign master_mode_o      = r.master;
   assign low_power_o        = (r.st != codec_clk_pkg::ST_CP_RUN) &&
                               (r.st != codec_clk_pkg::ST_PIN_RUN);

endmodule

// file: dv/codec_clk_ctrl_asserts.sv
// Checker for the mode and clock outputs.
// Assumes one clk_i domain; sees only top ports.
module codec_clk_ctrl_asserts #(
   parameter int WINDOW_CYCLES = 200,
   parameter int PWRUP_CYCLES  = 20
) (
   // Clock, reset and pins
   input wire logic                  clk_i,
   input wire logic                  rst_b_i,
   input wire logic                  format_select_pin_i,
   input wire logic                  crystal_fitted_i,
   input wire logic                  crystal_input_i,
   // Outputs watched
   input wire logic                  mclk_o,
   input wire logic                  mclk_oe_b_o,
   input wire logic                  frame_clock_oe_b_o,
   input wire logic                  bit_clock_oe_b_o,
   input wire codec_clk_pkg::speed_t speed_mode_o,
   input wire logic                  deemph_44k_o,
   input wire logic                  format_i2s_o,
   input wire logic                  fast_filter_o,
   input wire logic                  master_mode_o,
   input wire logic                  low_power_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Cycles since reset release, saturating
   logic [4:0] rel_cnt_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rel_cnt_r <= 5'h00;
      end else if (rel_cnt_r != 5'h1f) begin
         rel_cnt_r <= rel_cnt_r + 5'h01;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_filter_pin: assert property (deemph_44k_o |-> fast_filter_o)
      else $error("fast filter off in pin mode");
   chk_deemph_single: assert property (
      deemph_44k_o |-> speed_mode_o == codec_clk_pkg::SPD_SINGLE)
      else $error("de-emphasis outside single speed");
   chk_speed_legal: assert property (speed_mode_o != 2'h3)
      else $error("illegal speed code");
   chk_format_pin: assert property (
      (deemph_44k_o && $stable(format_select_pin_i))[*4] |->
      format_i2s_o == format_select_pin_i)
      else $error("format differs from pin");
   chk_slave_inputs: assert property (
      (!master_mode_o)[*3] |-> bit_clock_oe_b_o && frame_clock_oe_b_o)
      else $error("clock pins driven in slave mode");
   chk_asleep_quiet: assert property (
      low_power_o[*3] |-> bit_clock_oe_b_o && frame_clock_oe_b_o)
      else $error("clock pins driven in low power");
   chk_wake_low_power: assert property ($rose(rst_b_i) |-> low_power_o[*4])
      else $error("not in low power after reset");
   chk_mclk_driven: assert property (
      rel_cnt_r == 5'h10 && crystal_fitted_i |-> !mclk_oe_b_o)
      else $error("master clock not driven in time");
   chk_mclk_input: assert property ((!crystal_fitted_i)[*8] |-> mclk_oe_b_o)
      else $error("mclk driven without crystal");
   chk_mclk_follow: assert property (
      !mclk_oe_b_o && $rose(crystal_input_i) |-> ##[1:4] $rose(mclk_o))
      else $error("mclk not following crystal");

   // Main scenarios reached
   cov_deemph: cover property (deemph_44k_o);
   cov_master_run: cover property (!frame_clock_oe_b_o);
   cov_power_up: cover property ($fell(low_power_o));
endmodule

bind codec_clk_ctrl codec_clk_ctrl_asserts #(
   .WINDOW_CYCLES(WINDOW_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)) chk_u (
   .clk_i, .rst_b_i, .format_select_pin_i, .crystal_fitted_i, .crystal_input_i,
   .mclk_o, .mclk_oe_b_o, .frame_clock_oe_b_o, .bit_clock_oe_b_o, .speed_mode_o,
   .deemph_44k_o, .format_i2s_o, .fast_filter_o, .master_mode_o, .low_power_o);

// file: dv/codec_host_model.sv
// Host model: control port master and crystal.
// Assumes one task at a time; cclk idles low outside frames.
module codec_host_model (
   // Control port
   output logic      cclk_o,
   output logic      cs_b_o,
   output logic      cdin_o,
   input  wire logic cdout_i,
   // Crystal
   output logic      crystal_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // crystal, 40 ns period, free running
   initial begin
      crystal_o = 1'b0;
      forever #20 crystal_o = ~crystal_o;
   end

   initial begin
      cclk_o = 1'b0;
      cs_b_o = 1'b1;
      cdin_o = 1'b0;
   end

   // MSB first; data moves while cclk is low
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         cdin_o = b[i];
         #32 cclk_o = 1'b1;
         #32 cclk_o = 1'b0;
      end
   endtask

   // Sampled at cclk rise; cdin toggles
   task automatic get_byte(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         cdin_o = ~cdin_o;
         #32 cclk_o = 1'b1;
         b[i] = cdout_i;
         #32 cclk_o = 1'b0;
      end
   endtask

   // chip byte, map byte, optional data byte
   task automatic xfer(input logic [7:0] map, input logic [7:0] d, input logic wr);
      cs_b_o = 1'b0;
      #32 put_byte({codec_clk_pkg::CHIP_ADDR, 1'b0});
      put_byte(map);
      if (wr) put_byte(d);
      #32 cs_b_o = 1'b1;
      cdin_o = ~cdin_o;
      #64;
   endtask

   // Pointer frame, then a read frame
   task automatic read_reg(input logic [7:0] map, output logic [7:0] d);
      xfer(map, 8'h00, 1'b0);
      cs_b_o = 1'b0;
      #32 put_byte({codec_clk_pkg::CHIP_ADDR, 1'b1});
      get_byte(d);
      #32 cs_b_o = 1'b1;
      #64;
   endtask
endmodule

// file: dv/codec_mode_and_clock_setup_tb.sv
// Testbench: pin mode, port entry, power-up and clock ratios.
// Assumes the host model drives port and crystal.
module codec_mode_and_clock_setup_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WIN = 2000;  // Shortened port-enable window
   localparam int PWR = 100;   // Shortened power-up span
   localparam logic [7:0] MODES [5] = '{8'h39, 8'h18, 8'h88, 8'ha8, 8'hf8};
   localparam logic [15:0] RATIOS [5] = '{16'h200, 16'h100, 16'h80, 16'h100, 16'h80};
   localparam logic [15:0] SPDS [5] = '{16'h0, 16'h0, 16'h1, 16'h1, 16'h2};

   logic clk_i, rst_b_i, speed_select_high_i, speed_select_low_i, format_select_pin_i;
   logic serial_data_out_i, crystal_fitted_i, crystal_input_i, cclk_i, cs_b_i, cdin_i;
   logic mclk_o, mclk_oe_b_o, frame_clock_o, frame_clock_oe_b_o, bit_clock_o;
   logic bit_clock_oe_b_o, cdout_o, cdout_oe_b_o, deemph_44k_o, format_i2s_o;
   logic fast_filter_o, master_mode_o, low_power_o;
   codec_clk_pkg::speed_t speed_mode_o;
   int error_cnt = 0;
   int compares = 0;

   codec_clk_ctrl #(.WINDOW_CYCLES(WIN), .PWRUP_CYCLES(PWR)) dut_u (
      .clk_i, .rst_b_i, .speed_select_high_i, .speed_select_low_i, .format_select_pin_i,
      .serial_data_out_i, .crystal_fitted_i, .crystal_input_i, .mclk_i(1'b0), .mclk_o,
      .mclk_oe_b_o, .frame_clock_i(1'b0), .frame_clock_o, .frame_clock_oe_b_o,
      .bit_clock_i(1'b0), .bit_clock_o, .bit_clock_oe_b_o, .cclk_i, .cs_b_i, .cdin_i,
      .cdout_o, .cdout_oe_b_o, .speed_mode_o, .deemph_44k_o, .format_i2s_o,
      .fast_filter_o, .master_mode_o, .low_power_o);

   // Released data line reads inverted
   codec_host_model host_u (.cclk_o(cclk_i), .cs_b_o(cs_b_i), .cdin_o(cdin_i),
      .cdout_i(cdout_oe_b_o ? ~cdout_o : cdout_o), .crystal_o(crystal_input_i));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Straps change only while reset is low
   task automatic do_reset(input logic sdo, input logic xt);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      serial_data_out_i <= sdo;
      crystal_fitted_i <= xt;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
   endtask

   // Counts the second full frame, rise to rise
   task automatic measure(input logic [15:0] ratio);
      logic pf = 1'b1, pm = 1'b1, pb = 1'b1;
      int k = 0, n = 0;
      logic [15:0] nm = 16'h0, nb = 16'h0;
      while (k < 3 && n < 30000) begin
         @(negedge clk_i);
         n++;
         nm += 16'(mclk_o && !pm);
         nb += 16'(bit_clock_o && !pb);
         if (frame_clock_o && !pf) begin
            k++;
            if (k < 3) {nm, nb} = 32'h0;
         end
         {pf, pm, pb} = {frame_clock_o, mclk_o, bit_clock_o};
      end
      check("mclk per frame", ratio, nm);
      check("bits per frame", 16'h40, nb);
   endtask

   initial begin
      #400us;
      error_cnt++;
      $display("[ERR] watchdog expected done seen hang");
      tally_and_finish();
   end

   initial begin
      logic [7:0] rd;
      int n;
      {rst_b_i, speed_select_high_i, speed_select_low_i} = 3'h0;
      {format_select_pin_i, serial_data_out_i, crystal_fitted_i} = 3'h0;
      // Pin mode, master strap, every speed pin code
      do_reset(1'b1, 1'b1);
      repeat (WIN + 20) @(negedge clk_i);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         speed_select_high_i <= i[1];
         speed_select_low_i <= i[0];
         format_select_pin_i <= i[0];
         repeat (8) @(negedge clk_i);
         check("speed", (i < 2) ? 16'h0 : 16'(i - 1), speed_mode_o);
         check("deemph", 16'(i == 0), deemph_44k_o);
         check("i2s", 16'(i[0]), format_i2s_o);
         check("fast filter", 16'h1, fast_filter_o);
      end
      check("pin master", 16'h1, master_mode_o);
      check("mclk oe_b", 16'h0, mclk_oe_b_o);
      measure(16'h80);
      $display("test pin_master done");
      // Port entry, setup while down, power-up, ratio table
      do_reset(1'b0, 1'b1);
      check("low power", 16'h1, low_power_o);
      host_u.read_reg(8'h07, rd);
      check("power reg", 16'h00, rd);
      repeat (200) @(negedge clk_i);
      host_u.xfer(8'h07, 8'h03, 1'b1);
      check("slave default", 16'h0, master_mode_o);
      host_u.xfer(8'h01, 8'h39, 1'b1);
      host_u.read_reg(8'h01, rd);
      check("mode reg", 16'h39, rd);
      host_u.read_reg(8'h05, rd);
      check("unmapped", 16'h00, rd);
      host_u.xfer(8'h07, 8'h02, 1'b1);
      check("powering", 16'h1, low_power_o);
      n = 0;
      while (low_power_o !== 1'b0 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      check("power-up span", 16'h1, 16'(n > PWR - 30 && n <= PWR));
      check("master on", 16'h1, master_mode_o);
      check("deemph off", 16'h0, deemph_44k_o);
      for (int j = 0; j < 5; j++) begin
         host_u.xfer(8'h01, MODES[j], 1'b1);
         check("port speed", SPDS[j], speed_mode_o);
         measure(RATIOS[j]);
      end
      $display("test port_mode done");
      // Reset mid-run, then pin mode slave without crystal
      do_reset(1'b0, 1'b0);
      host_u.read_reg(8'h01, rd);
      check("mode reset", 16'h00, rd);
      repeat (WIN + 20) @(negedge clk_i);
      check("pin slave", 16'h0, master_mode_o);
      check("mclk input", 16'h1, mclk_oe_b_o);
      $display("test pin_slave done");
      tally_and_finish();
   end
endmodule
